// ==== rtl/mssc_defs.vh ====
// constants for the motor statistics and setpoint editing block
// assumes a 100 MHz clk_sys and word-addressed avalon-mm register access
//
// Operation
// R01: running above 7% full load; time accrues
// R02: count start when current leaves zero
// R03: total trips counts every trip cause
// R04: overload trip at full thermal capacity counted
// R05: thermistor hot trip counted, either sensor type
// R06: ground fault trip above setpoint counted
// R07: single phase unbalance trip counted
// R08: slow acceleration trips motor, counted
// R09: undercurrent trip only when enabled, running
// R10: stalled rotor trips only while running
// R11: interlock or isolator opening trips, counted; the code trips only while motor_running
// R12: setpoints key opens page one line one; the code opens page one at line zero
// R13: two idle minutes return default display; the code times out only in setpoints mode
// R14: page and line keys browse setpoints
// R15: value keys adjust; store commits, flashes
// R16: store without access discards, flashes illegal
// R17: stored setpoints survive power removal
// R18: setpoints editable while motor runs
// R19: page key after statistics returns page one
// R20: test position freezes start and trip counters
// R21: counters saturate, never wrap
`ifndef MSSC_DEFS_VH
`define MSSC_DEFS_VH

// ************************************************
// timing
// ************************************************
`define MSSC_CLK_HZ         36'h5F5E100
`define MSSC_IDLE_MIN       36'h2
`define MSSC_IDLE_CYCLES    (`MSSC_IDLE_MIN * 36'h3C * `MSSC_CLK_HZ)
`define MSSC_TICK_MS        36'h64
`define MSSC_TICK_CYCLES    (`MSSC_TICK_MS * (`MSSC_CLK_HZ / 36'h3E8))
`define MSSC_FLASH_MS       36'h7D0
`define MSSC_FLASH_CYCLES   (`MSSC_FLASH_MS * (`MSSC_CLK_HZ / 36'h3E8))
`define MSSC_TICKS_PER_S    4'hA
`define MSSC_ACCEL_STEP_T   20'h5
`define MSSC_STALL_DLY_T    20'h14
`define MSSC_UC_DLY_T       20'h64

// ************************************************
// current thresholds
// ************************************************
`define MSSC_RUN_PCT        24'h7
`define MSSC_PCT_FULL       24'h64
`define MSSC_STALL_SCALE    24'hA

// ************************************************
// display modes, flash messages
// ************************************************
`define MSSC_MODE_DEFAULT   2'h0
`define MSSC_MODE_ACTUAL    2'h1
`define MSSC_MODE_SETPT     2'h2
`define MSSC_FLASH_NONE     2'h0
`define MSSC_FLASH_STORED   2'h1
`define MSSC_FLASH_ILLEGAL  2'h2

// ************************************************
// pages, lines, setpoint items
// ************************************************
`define MSSC_SP_PAGES       2'h3
`define MSSC_SP_LINES_P1    4'hC
`define MSSC_SP_LINES_P2    4'hE
`define MSSC_SP_LINES_P3    4'h3
`define MSSC_SP_BASE_P2     5'h0C
`define MSSC_SP_BASE_P3     5'h1A
`define MSSC_AV_PAGES       3'h4
`define MSSC_AV_LINES       5'h11
`define MSSC_AV_LINES_STAT  5'h0D
`define MSSC_IDX_FLC        5'h03
`define MSSC_IDX_ACCEL      5'h04
`define MSSC_IDX_STALL      5'h07
`define MSSC_IDX_UC         5'h08

// ************************************************
// key and pin bit positions, trip causes
// ************************************************
`define MSSC_KEY_SETPT      0
`define MSSC_KEY_ACTUAL     1
`define MSSC_KEY_PAGE       2
`define MSSC_KEY_UP         3
`define MSSC_KEY_DOWN       4
`define MSSC_KEY_VUP        5
`define MSSC_KEY_VDOWN      6
`define MSSC_KEY_STORE      7
`define MSSC_PIN_TEST       0
`define MSSC_PIN_ACCESS     1
`define MSSC_PIN_INTERLOCK  2
`define MSSC_PIN_ISOLATOR   3
`define MSSC_NUM_CAUSES     8
`define MSSC_NUM_COUNTERS   10

// ************************************************
// register word offsets
// ************************************************
`define MSSC_REG_CTRL       5'h00
`define MSSC_REG_STATUS     5'h01
`define MSSC_REG_RUN_SEC    5'h02
`define MSSC_REG_SP_INDEX   5'h03
`define MSSC_REG_SP_DATA    5'h04
`define MSSC_REG_CNT_BASE   5'h08
`define MSSC_CTRL_CLEAR     0

`endif

// ==== rtl/mssc_sat_counter.v ====
// one saturating 16-bit statistics counter
// assumes inc and clear come from logic on clk_sys
`timescale 1ns/1ps
module mssc_sat_counter (
   // clock and reset
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        clk_en,
   // control
   input  wire        clear,
   input  wire        inc,
   // value
   output reg  [15:0] count
);
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count <= 16'h0000;
      end else if (clk_en) begin
         // an event in the clearing cycle still counts
         if (clear) begin
            count <= inc ? 16'h0001 : 16'h0000;
         end else if (inc && count != 16'hFFFF) begin
            count <= count + 16'h0001; // see R21
         end
      end
   end
endmodule

// ==== rtl/mssc_top.v ====
// motor statistics, trip detectors and keypad setpoint editor
// assumes keys and contact pins are raw pin levels, current and
// external trip pulses come from protection logic on clk_sys
`timescale 1ns/1ps
`include "mssc_defs.vh"
module mssc_top #(
   parameter [35:0] IDLE_CYCLES  = `MSSC_IDLE_CYCLES,
   parameter [35:0] TICK_CYCLES  = `MSSC_TICK_CYCLES,
   parameter [35:0] FLASH_CYCLES = `MSSC_FLASH_CYCLES
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        clk_en,
   // avalon-mm slave
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // keypad and contact pins, closed is high
   input  wire [7:0]  key_pin,
   input  wire [3:0]  contact_pin,
   // protection logic
   input  wire [15:0] motor_current,
   input  wire        trip_overload,
   input  wire        trip_thermistor,
   input  wire        trip_ground_fault,
   input  wire        trip_single_phase,
   // trip and display outputs
   output reg         motor_running,
   output reg         motor_trip,
   output reg  [2:0]  trip_cause,
   output reg  [1:0]  disp_mode,
   output reg  [2:0]  disp_page,
   output reg  [4:0]  disp_line,
   output reg  [15:0] edit_value,
   output reg  [1:0]  flash_msg
);
   // ************************************************
   // pin synchronisers
   // ************************************************
   reg  [7:0]  key_meta;
   reg  [7:0]  key_sync;
   reg  [7:0]  key_prev;
   reg  [3:0]  pin_meta;
   reg  [3:0]  pin_sync;
   reg  [3:0]  pin_prev;
   wire [7:0]  key_press = key_sync & ~key_prev;
   wire        any_key   = |key_press;
   wire        test_pos  = pin_sync[`MSSC_PIN_TEST];
   wire        access_ok = pin_sync[`MSSC_PIN_ACCESS];

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         key_meta <= 8'h00;
         key_sync <= 8'h00;
         key_prev <= 8'h00;
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
         pin_prev <= 4'h0;
      end else if (clk_en) begin
         key_meta <= key_pin;
         key_sync <= key_meta;
         key_prev <= key_sync;
         pin_meta <= contact_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ************************************************
   // setpoint store, no reset so contents persist
   // ************************************************
   reg  [15:0] sp_mem [0:31];
   reg  [4:0]  sp_index;
   wire [15:0] flc_set   = sp_mem[`MSSC_IDX_FLC];
   wire [15:0] accel_set = sp_mem[`MSSC_IDX_ACCEL];
   wire [15:0] stall_set = sp_mem[`MSSC_IDX_STALL];
   wire [15:0] uc_set    = sp_mem[`MSSC_IDX_UC];
   // 32 bits so that current times a 16-bit setpoint never overflows
   wire [31:0] cur_w     = {16'h0000, motor_current};
   wire [31:0] flc_w     = {16'h0000, flc_set};

   // ************************************************
   // time base
   // ************************************************
   reg  [35:0] tick_cnt;
   reg         tick;
   reg  [3:0]  sec_cnt;
   reg  [31:0] run_seconds;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tick_cnt <= 36'h000000000;
         tick     <= 1'b0;
      end else if (clk_en) begin
         tick <= (tick_cnt == TICK_CYCLES - 36'h000000001);
         if (tick_cnt == TICK_CYCLES - 36'h000000001) begin
            tick_cnt <= 36'h000000000;
         end else begin
            tick_cnt <= tick_cnt + 36'h000000001;
         end
      end
   end

   // ************************************************
   // running state, starts, running time
   // ************************************************
   reg         from_zero;
   reg         start_pulse;
   wire        next_running = (cur_w * `MSSC_PCT_FULL) > (flc_w * `MSSC_RUN_PCT); // see R01

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         motor_running <= 1'b0;
         from_zero     <= 1'b0;
         start_pulse   <= 1'b0;
         sec_cnt       <= 4'h0;
         run_seconds   <= 32'h00000000;
      end else if (clk_en) begin
         motor_running <= next_running;
         // a start needs current to have been zero first
         start_pulse   <= from_zero && next_running; // see R02
         if (motor_current == 16'h0000) begin
            from_zero <= 1'b1;
         end else if (next_running) begin
            from_zero <= 1'b0;
         end
         if (tick && motor_running) begin // see R01
            if (sec_cnt == `MSSC_TICKS_PER_S - 4'h1) begin
               sec_cnt <= 4'h0;
               if (run_seconds != 32'hFFFFFFFF) begin
                  run_seconds <= run_seconds + 32'h00000001; // see R21
               end
            end else begin
               sec_cnt <= sec_cnt + 4'h1;
            end
         end
      end
   end

   // ************************************************
   // internal trip detectors
   // ************************************************
   reg         accel_active;
   reg  [19:0] accel_t;
   reg  [19:0] stall_t;
   reg  [19:0] uc_t;
   reg         accel_trip;
   reg         stall_trip;
   reg         uc_trip;
   wire        at_flc    = motor_current >= flc_set;
   wire        stall_on  = stall_set != 16'h0000;
   wire        over_st   = (cur_w * `MSSC_STALL_SCALE) > (flc_w * {8'h00, stall_set});
   wire        uc_on     = uc_set != 16'h0000;
   wire        under_uc  = (cur_w * `MSSC_PCT_FULL) < (flc_w * {8'h00, uc_set});
   wire        ctrl_trip = motor_running &&
                           ((pin_prev[`MSSC_PIN_INTERLOCK] && !pin_sync[`MSSC_PIN_INTERLOCK]) ||
                            (pin_prev[`MSSC_PIN_ISOLATOR] && !pin_sync[`MSSC_PIN_ISOLATOR]));
   wire [19:0] accel_lim = accel_set[14:0] * `MSSC_ACCEL_STEP_T;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         accel_active <= 1'b0;
         accel_t      <= 20'h00000;
         stall_t      <= 20'h00000;
         uc_t         <= 20'h00000;
         accel_trip   <= 1'b0;
         stall_trip   <= 1'b0;
         uc_trip      <= 1'b0;
      end else if (clk_en) begin
         accel_trip <= 1'b0;
         stall_trip <= 1'b0;
         uc_trip    <= 1'b0;
         // zero acceleration setpoint means off
         if (start_pulse) begin
            accel_active <= accel_set != 16'h0000;
            accel_t      <= 20'h00000;
         end else if (accel_active) begin
            if (at_flc || !motor_running) begin
               accel_active <= 1'b0;
            end else if (accel_t >= accel_lim) begin
               accel_active <= 1'b0;
               accel_trip   <= 1'b1; // see R08
            end else if (tick) begin
               accel_t <= accel_t + 20'h00001;
            end
         end
         // stall only watched once running and past startup
         if (!(motor_running && !accel_active && stall_on && over_st)) begin
            stall_t <= 20'h00000; // see R10
         end else if (stall_t >= `MSSC_STALL_DLY_T) begin
            stall_t    <= 20'h00000;
            stall_trip <= 1'b1; // see R10
         end else if (tick) begin
            stall_t <= stall_t + 20'h00001;
         end
         if (!(motor_running && uc_on && under_uc)) begin
            uc_t <= 20'h00000; // see R09
         end else if (uc_t >= `MSSC_UC_DLY_T) begin
            uc_t    <= 20'h00000;
            uc_trip <= 1'b1; // see R09
         end else if (tick) begin
            uc_t <= uc_t + 20'h00001;
         end
      end
   end

   // ************************************************
   // trip merge, lowest cause wins on a tie
   // ************************************************
   wire [7:0] trip_req = {ctrl_trip, stall_trip, uc_trip, accel_trip,
                          trip_single_phase, trip_ground_fault,
                          trip_thermistor, trip_overload};
   reg  [2:0] next_cause;
   integer    i;

   always @* begin
      next_cause = 3'h0;
      for (i = `MSSC_NUM_CAUSES - 1; i >= 0; i = i - 1) begin
         if (trip_req[i]) begin
            next_cause = i[2:0];
         end
      end
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         motor_trip <= 1'b0;
         trip_cause <= 3'h0;
      end else if (clk_en) begin
         motor_trip <= |trip_req; // see R08
         if (|trip_req) begin
            trip_cause <= next_cause;
         end
      end
   end

   // ************************************************
   // statistics counters
   // ************************************************
   reg          stat_clear;
   wire [159:0] cnt_bus;
   wire [9:0]   cnt_inc;

   assign cnt_inc[0] = start_pulse && !test_pos; // see R02
   assign cnt_inc[1] = motor_trip && !test_pos; // see R03

   genvar g;
   generate
      for (g = 0; g < `MSSC_NUM_COUNTERS; g = g + 1) begin : g_cnt
         if (g >= 2) begin : g_cause
            // see R04, R05, R06, R07, R11 and R20
            assign cnt_inc[g] = motor_trip && !test_pos && (trip_cause == g - 2);
         end
         mssc_sat_counter u_cnt (
            .clk_sys (clk_sys),
            .reset   (reset),
            .clk_en  (clk_en),
            .clear   (stat_clear),
            .inc     (cnt_inc[g]),
            .count   (cnt_bus[g*16 +: 16])
         );
      end
   endgenerate

   // ************************************************
   // display and editor state
   // ************************************************
   reg  [35:0] idle_cnt;
   reg  [35:0] flash_cnt;
   reg         reload;
   reg  [3:0]  sp_lines;
   reg  [4:0]  sp_item;
   reg  [4:0]  av_lines;
   wire        in_sp     = disp_mode == `MSSC_MODE_SETPT;
   wire        on_item   = in_sp && disp_line != 5'h00;
   wire        store_ok  = on_item && key_press[`MSSC_KEY_STORE] && access_ok;

   always @* begin
      case (disp_page)
         3'h1: begin
            sp_lines = `MSSC_SP_LINES_P1;
            sp_item  = disp_line - 5'h01;
         end
         3'h2: begin
            sp_lines = `MSSC_SP_LINES_P2;
            sp_item  = `MSSC_SP_BASE_P2 + disp_line - 5'h01;
         end
         default: begin
            sp_lines = `MSSC_SP_LINES_P3;
            sp_item  = `MSSC_SP_BASE_P3 + disp_line - 5'h01;
         end
      endcase
      av_lines = (disp_page == `MSSC_AV_PAGES) ? `MSSC_AV_LINES_STAT : `MSSC_AV_LINES;
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         disp_mode  <= `MSSC_MODE_DEFAULT;
         disp_page  <= 3'h1;
         disp_line  <= 5'h00;
         edit_value <= 16'h0000;
         flash_msg  <= `MSSC_FLASH_NONE;
         idle_cnt   <= 36'h000000000;
         flash_cnt  <= 36'h000000000;
         reload     <= 1'b0;
      end else if (clk_en) begin
         reload <= 1'b0;
         if (reload) begin
            edit_value <= sp_mem[sp_item];
         end
         idle_cnt <= (any_key || !in_sp) ? 36'h000000000 : idle_cnt + 36'h000000001;
         if (flash_cnt != 36'h000000000) begin
            flash_cnt <= flash_cnt - 36'h000000001;
         end else begin
            flash_msg <= `MSSC_FLASH_NONE;
         end
         if (key_press[`MSSC_KEY_SETPT]) begin
            disp_mode <= `MSSC_MODE_SETPT; // see R12
            disp_page <= 3'h1;
            disp_line <= 5'h00;
         end else if (key_press[`MSSC_KEY_ACTUAL]) begin
            disp_mode <= `MSSC_MODE_ACTUAL;
            disp_page <= 3'h1;
            disp_line <= 5'h01;
         end else if (in_sp && idle_cnt > IDLE_CYCLES) begin
            disp_mode <= `MSSC_MODE_DEFAULT; // see R13
         end else if (in_sp) begin
            // store takes no notice of motor state
            if (key_press[`MSSC_KEY_PAGE]) begin // see R14
               disp_page <= (disp_page == {1'b0, `MSSC_SP_PAGES}) ? 3'h1 : disp_page + 3'h1;
               disp_line <= 5'h00;
            end else if (key_press[`MSSC_KEY_DOWN]) begin
               disp_line <= (disp_line == {1'b0, sp_lines}) ? 5'h00 : disp_line + 5'h01;
               reload    <= 1'b1;
            end else if (key_press[`MSSC_KEY_UP]) begin
               disp_line <= (disp_line == 5'h00) ? {1'b0, sp_lines} : disp_line - 5'h01;
               reload    <= 1'b1;
            end else if (on_item && key_press[`MSSC_KEY_VUP] && edit_value != 16'hFFFF) begin
               edit_value <= edit_value + 16'h0001; // see R15
            end else if (on_item && key_press[`MSSC_KEY_VDOWN] && edit_value != 16'h0000) begin
               edit_value <= edit_value - 16'h0001; // see R15
            end else if (on_item && key_press[`MSSC_KEY_STORE]) begin
               flash_cnt <= FLASH_CYCLES;
               if (access_ok) begin
                  flash_msg <= `MSSC_FLASH_STORED; // see R15, R18
               end else begin
                  flash_msg <= `MSSC_FLASH_ILLEGAL; // see R16
                  reload    <= 1'b1;
               end
            end
         end else if (disp_mode == `MSSC_MODE_ACTUAL) begin
            if (key_press[`MSSC_KEY_PAGE]) begin
               disp_page <= (disp_page == `MSSC_AV_PAGES) ? 3'h1 : disp_page + 3'h1; // see R19
               disp_line <= 5'h01;
            end else if (key_press[`MSSC_KEY_DOWN]) begin
               disp_line <= (disp_line == av_lines) ? 5'h01 : disp_line + 5'h01;
            end else if (key_press[`MSSC_KEY_UP]) begin
               disp_line <= (disp_line == 5'h01) ? av_lines : disp_line - 5'h01;
            end
         end
      end
   end

   // ************************************************
   // avalon-mm slave, one wait state per access
   // ************************************************
   wire        bus_req = avs_read || avs_write;
   wire        bus_acc = bus_req && !avs_waitrequest;
   wire [4:0]  cnt_idx = avs_address - `MSSC_REG_CNT_BASE;
   reg  [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h00000000;
      case (avs_address)
         `MSSC_REG_STATUS:   next_rdata = {16'h0000, flash_msg, disp_mode, disp_page,
                                           disp_line, test_pos, access_ok, motor_trip,
                                           motor_running};
         `MSSC_REG_RUN_SEC:  next_rdata = run_seconds;
         `MSSC_REG_SP_INDEX: next_rdata = {27'h0000000, sp_index};
         `MSSC_REG_SP_DATA:  next_rdata = {16'h0000, sp_mem[sp_index]};
         default: begin
            if (avs_address >= `MSSC_REG_CNT_BASE &&
                cnt_idx < `MSSC_NUM_COUNTERS) begin
               next_rdata = {16'h0000, cnt_bus[cnt_idx*16 +: 16]};
            end
         end
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         sp_index        <= 5'h00;
         stat_clear      <= 1'b0;
      end else if (clk_en) begin
         stat_clear      <= 1'b0;
         avs_waitrequest <= !(bus_req && avs_waitrequest);
         if (bus_req && avs_waitrequest) begin
            avs_readdata <= avs_read ? next_rdata : 32'h00000000;
         end
         if (bus_acc && avs_write) begin
            if (avs_address == `MSSC_REG_SP_INDEX) begin
               sp_index <= avs_writedata[4:0];
            end
            if (avs_address == `MSSC_REG_CTRL) begin
               stat_clear <= avs_writedata[`MSSC_CTRL_CLEAR];
            end
         end
      end
   end

   // the keypad store wins; a bus write in that cycle is dropped
   always @(posedge clk_sys) begin
      if (clk_en) begin
         if (store_ok) begin
            sp_mem[sp_item] <= edit_value; // see R15, R17
         end else if (bus_acc && avs_write && avs_address == `MSSC_REG_SP_DATA) begin
            sp_mem[sp_index] <= avs_writedata[15:0];
         end
      end
   end
endmodule

// ==== verif/mssc_chk.sv ====
// assertions on the statistics and setpoint block ports
// assumes clk_en held high
`timescale 1ns/1ps
module mssc_chk (
   // clock and reset
   input wire       clk_sys,
   input wire       reset,
   // inputs watched
   input wire [7:0] key_pin,
   input wire       trip_overload,
   input wire       trip_thermistor,
   input wire       trip_ground_fault,
   input wire       trip_single_phase,
   // outputs watched
   input wire       motor_trip,
   input wire [2:0] trip_cause,
   input wire [1:0] disp_mode,
   input wire [2:0] disp_page,
   input wire [4:0] disp_line,
   input wire [1:0] flash_msg
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   ovl_trip_a: assert property (trip_overload |=> motor_trip && trip_cause == 3'h0)
      else $error("overload trip wrong");
   therm_trip_a: assert property (trip_thermistor && !trip_overload |=>
      motor_trip && trip_cause == 3'h1) else $error("thermistor trip wrong");
   gnd_trip_a: assert property (trip_ground_fault && !trip_overload &&
      !trip_thermistor |=> trip_cause == 3'h2) else $error("ground trip wrong");
   phase_trip_a: assert property (trip_single_phase && !trip_overload &&
      !trip_thermistor && !trip_ground_fault |=> motor_trip && trip_cause == 3'h3)
      else $error("single phase trip wrong");
   setpt_key_a: assert property ($rose(key_pin[0]) |-> ##[3:4]
      (disp_mode == 2'h2 && disp_page == 3'h1 && disp_line == 5'h0)) else $error("entry wrong");
   sp_page_a: assert property (disp_mode == 2'h2 && $changed(disp_page) |->
      disp_line == 5'h0 && disp_page inside {[1:3]}) else $error("page step wrong");
   flash_hold_a: assert property (flash_msg != 2'h0 && $past(flash_msg) == 2'h0 |->
      (flash_msg != 2'h0) [*8]) else $error("flash too short");
   page_wrap_a: assert property (disp_mode == 2'h1 && $past(disp_page) == 3'h4 &&
      disp_page != 3'h4 |-> disp_page == 3'h1) else $error("page wrap wrong");
endmodule

// ==== verif/mssc_keypad.sv ====
// keypad model: one key held five clocks per request
// assumes requests spaced beyond the hold time
`timescale 1ns/1ps
module mssc_keypad (
   // clock
   input  wire       clk_sys,
   // request
   input  wire       key_go,
   input  wire [2:0] key_num,
   // pins, pressed is high
   output reg  [7:0] key_pin
);
   reg [2:0] hold;
   initial begin
      key_pin = 8'h00;
      hold    = 3'h0;
   end
   always @(posedge clk_sys) begin
      if (key_go) begin
         key_pin <= 8'h01 << key_num;
         hold    <= 3'h4;
      end else if (hold != 3'h0) begin
         hold <= hold - 3'h1;
      end else begin
         key_pin <= 8'h00;  // released key reads open
      end
   end
endmodule

// ==== verif/mssc_top_tb.sv ====
// self-checking bench for the statistics and setpoint block
// assumes mssc_defs.vh on the include path
`timescale 1ns/1ps
`include "mssc_defs.vh"
module mssc_top_tb;
   logic        clk_sys, reset, avs_read, avs_write, key_go;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, rd;
   logic [2:0]  key_num;
   logic [3:0]  contact_pin, trp;
   logic [15:0] motor_current;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, motor_running, motor_trip;
   wire  [7:0]  key_pin;
   wire  [2:0]  trip_cause, disp_page;
   wire  [1:0]  disp_mode, flash_msg;
   wire  [4:0]  disp_line;
   wire  [15:0] edit_value;
   int          fail_count, total_checks, seed, i, c;
   int          cnt [4];
   // short counts keep idle, tick and flash inside the run
   mssc_top #(.IDLE_CYCLES(36'hC8), .TICK_CYCLES(36'hA), .FLASH_CYCLES(36'h14)) mssc_top_i (
      .clk_sys, .reset, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .key_pin, .contact_pin, .motor_current,
      .trip_overload(trp[0]), .trip_thermistor(trp[1]), .trip_ground_fault(trp[2]),
      .trip_single_phase(trp[3]), .motor_running, .motor_trip, .trip_cause, .disp_mode,
      .disp_page, .disp_line, .edit_value, .flash_msg);
   mssc_keypad mssc_keypad_i (.clk_sys, .key_go, .key_num, .key_pin);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task press(input logic [2:0] k);
      key_num <= k;
      key_go <= 1'b1;
      @(posedge clk_sys);
      key_go <= 1'b0;
      repeat (10) @(posedge clk_sys);
   endtask
   task give_verdict;
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      give_verdict;
   end
   initial begin
      {seed, fail_count, total_checks, reset} = {32'd79, 64'd0, 1'b1};
      {avs_read, avs_write, avs_address, avs_writedata, key_go, key_num} = '0;
      {contact_pin, trp, motor_current} = {4'hC, 20'h0};
      cnt = '{0, 0, 0, 0};
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      // full load 100, stall level out of reach, other items off
      for (i = 0; i < 29; i++) begin
         bus(1'b1, `MSSC_REG_SP_INDEX, i);
         bus(1'b1, `MSSC_REG_SP_DATA, i == 3 ? 100 : (i == 7 ? 32'hFFFF : 0));
      end
      motor_current <= 16'h7;
      repeat (4) @(posedge clk_sys);
      chk(motor_running, 1'b0);
      motor_current <= 16'h8;
      repeat (4) @(posedge clk_sys);
      chk(motor_running, 1'b1);
      rdchk(`MSSC_REG_CNT_BASE, 1);
      for (i = 0; i < 17; i++) begin
         c = i == 16 ? 1 : $unsigned($random(seed)) % 4;
         motor_current <= 16'h8 + 16'($unsigned($random(seed)) % 200);
         trp <= i == 16 ? 4'hA : 4'h1 << c;  // tie counts once as lowest cause
         cnt[c]++;
         @(posedge clk_sys);
         trp <= 4'h0;
         repeat (3) @(posedge clk_sys);
      end
      contact_pin <= 4'h8;
      repeat (8) @(posedge clk_sys);
      chk(trip_cause, 3'h7);
      contact_pin <= 4'hD;
      for (i = 0; i < 4; i++) rdchk(5'(`MSSC_REG_CNT_BASE + 2 + i), cnt[i]);
      rdchk(`MSSC_REG_CNT_BASE + 5'h9, 1);
      trp <= 4'h1;
      @(posedge clk_sys);
      trp <= 4'h0;
      repeat (4) @(posedge clk_sys);
      rdchk(`MSSC_REG_CNT_BASE + 5'h1, 18);
      contact_pin <= 4'h8;
      press(`MSSC_KEY_SETPT);
      chk({disp_mode, disp_page, disp_line}, {2'h2, 3'h1, 5'h0});
      for (i = 0; i < 3; i++) press(`MSSC_KEY_PAGE);
      press(`MSSC_KEY_DOWN);
      chk({disp_page, disp_line}, {3'h1, 5'h1});
      press(`MSSC_KEY_VUP);
      chk(edit_value, 16'h1);
      press(`MSSC_KEY_STORE);
      chk({flash_msg, edit_value}, {2'h2, 16'h0});
      contact_pin <= 4'hE;
      press(`MSSC_KEY_VUP);
      press(`MSSC_KEY_STORE);
      chk(flash_msg, 2'h1);
      bus(1'b1, `MSSC_REG_SP_INDEX, 0);
      rdchk(`MSSC_REG_SP_DATA, 1);
      repeat (150) @(posedge clk_sys);
      chk(disp_mode, 2'h2);
      repeat (110) @(posedge clk_sys);
      chk(disp_mode, 2'h0);
      press(`MSSC_KEY_ACTUAL);
      for (i = 0; i < 4; i++) press(`MSSC_KEY_PAGE);
      chk({disp_mode, disp_page}, {2'h1, 3'h1});
      // about five seconds of running at ten ticks per second
      bus(1'b0, `MSSC_REG_RUN_SEC, 0);
      chk(rd >= 2 && rd <= 9, 1);
      give_verdict;
   end
endmodule
bind mssc_top mssc_chk mssc_chk_i (.clk_sys, .reset, .key_pin, .trip_overload,
   .trip_thermistor, .trip_ground_fault, .trip_single_phase, .motor_trip, .trip_cause,
   .disp_mode, .disp_page, .disp_line, .flash_msg);
